// ### pkg/lpd_pkg.sv
package lpd_pkg;
  // ***********************
  // register map
  // ***********************
  localparam logic [7:0] REG_CHIP_CTRL = 8'h00;
  localparam logic [7:0] REG_CHANNEL_OPERATING_MODE = 8'h01;
  localparam logic [7:0] REG_CONFIG = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0c;
  localparam logic [7:0] REG_SOFT_RST = 8'h0d;
  localparam logic [7:0] REG_OUT_PIN = 8'h0e;
  localparam logic [7:0] SOFT_RST_KEY = 8'hff;
  localparam logic [7:0] CONFIG_RESET = 8'h00;
  localparam logic [2:0] OUT_PIN_RESET = 3'h0;
  localparam logic [5:0] CHANNEL_OPERATING_MODE_RESET = 6'h00;
  // ***********************
  // field positions
  // ***********************
  localparam int CHIP_EN_BIT = 0;
  localparam int CLK_DET_BIT = 1;
  localparam int EXT_USED_BIT = 0;
  localparam int INT_ROLE_BIT = 2;
  localparam int GPO_BIT = 1;
  localparam int INT_LVL_BIT = 0;
  localparam int CHANNEL_OPERATING_MODE_W = 6;
  localparam logic [1:0] CLK_EXT = 2'h0;
  localparam logic [1:0] CLK_AUTO = 2'h2;
  // ***********************
  // timing
  // ***********************
  localparam int SYS_CLK_HZ = 250_000_000;
  localparam int INT_OSC_HZ = 32768;
  localparam int EXT_MIN_HZ = 15000;
  localparam int EN_START_US = 1000;
  localparam int CE_START_US = 500;
  localparam int INT_OSC_CYC = SYS_CLK_HZ / INT_OSC_HZ;
  localparam int EXT_LOSS_CYC = SYS_CLK_HZ / EXT_MIN_HZ;
  localparam int EN_START_CYC = (SYS_CLK_HZ / 1_000_000) * EN_START_US;
  localparam int CE_START_CYC = (SYS_CLK_HZ / 1_000_000) * CE_START_US;
  localparam logic [1:0] TRIGGER_LINE_IN_TICKS = 2'h2;
  localparam logic [1:0] TRIGGER_LINE_OUT_TICKS = 2'h3;
  localparam logic [6:0] I2C_BASE_ADDR = 7'h32;
  // ***********************
  // types
  // ***********************
  typedef enum logic [2:0] {
    MODE_RESET = 3'h0,
    MODE_STANDBY = 3'h1,
    MODE_STARTUP = 3'h2,
    MODE_NORMAL = 3'h3,
    MODE_PSAVE = 3'h4
  } lpd_mode_t;
  typedef struct packed {
    logic valid;
    logic [7:0] addr;
    logic [7:0] data;
  } lpd_wr_t;
endpackage

// ### design/lpd_i2c_slave.sv
`timescale 1ns/1ps
module lpd_i2c_slave (
  input wire logic i_sys_clk,
  input wire logic i_sys_rst,
  input wire logic i_scl,
  input wire logic i_sda,
  input wire logic [1:0] i_addr_sel,
  input wire logic [7:0] i_rd_data,
  output logic [7:0] o_rd_addr,
  output lpd_pkg::lpd_wr_t o_wr,
  output logic o_sda_oe
);
  typedef enum logic [2:0] {
    I_IDLE = 3'h0,
    I_RX = 3'h1,
    I_ACK = 3'h2,
    I_TX = 3'h3,
    I_TACK = 3'h4
  } lpd_i2c_st_t;
  // ***********************
  // pin sampling
  // ***********************
  logic [2:0] scl_r;
  logic [2:0] sda_r;
  logic [1:0] sel_m;
  logic [1:0] sel_s;
  always_ff @(posedge i_sys_clk)
  begin
    if (i_sys_rst)
    begin
      scl_r <= 3'h7;
      sda_r <= 3'h7;
      sel_m <= 2'h0;
      sel_s <= 2'h0;
    end
    else
    begin
      scl_r <= {scl_r[1:0], i_scl};
      sda_r <= {sda_r[1:0], i_sda};
      sel_m <= i_addr_sel;
      sel_s <= sel_m;
    end
  end
  logic scl_hi;
  logic scl_rise;
  logic scl_fall;
  logic start;
  logic stop;
  logic [6:0] my_addr;
  assign scl_hi = scl_r[1] && scl_r[2];
  assign scl_rise = scl_r[1] && !scl_r[2];
  assign scl_fall = !scl_r[1] && scl_r[2];
  // any sda move while scl is high ends the transfer in flight
  assign start = scl_hi && !sda_r[1] && sda_r[2];
  assign stop = scl_hi && sda_r[1] && !sda_r[2];
  assign my_addr = lpd_pkg::I2C_BASE_ADDR + {5'h00, sel_s};
  // ***********************
  // byte engine
  // ***********************
  lpd_i2c_st_t st;
  logic [7:0] sr;
  logic [3:0] bits;
  logic [1:0] idx;
  logic rw;
  logic nack;
  always_ff @(posedge i_sys_clk)
  begin
    if (i_sys_rst)
    begin
      st <= I_IDLE;
      sr <= 8'h00;
      bits <= 4'h0;
      idx <= 2'h0;
      rw <= 1'b0;
      nack <= 1'b0;
      o_rd_addr <= 8'h00;
      o_wr <= '0;
      o_sda_oe <= 1'b0;
    end
    else
    begin
      o_wr.valid <= 1'b0;
      if (start)
      begin
        st <= I_RX;
        bits <= 4'h0;
        idx <= 2'h0;
        o_sda_oe <= 1'b0;
      end
      else if (stop)
      begin
        st <= I_IDLE;
        o_sda_oe <= 1'b0;
      end
      else
      begin
        case (st)
          I_RX:
            if (scl_rise)
            begin
              sr <= {sr[6:0], sda_r[1]};
              bits <= bits + 4'h1;
            end
            else if (scl_fall && bits == 4'h8)
            begin
              bits <= 4'h0;
              st <= I_ACK;
              o_sda_oe <= 1'b1;
              if (idx != 2'h2)
                idx <= idx + 2'h1;
              if (idx == 2'h0)
              begin
                rw <= sr[0];
                if (sr[7:1] != my_addr)
                begin
                  st <= I_IDLE;
                  o_sda_oe <= 1'b0;
                end
              end
              else if (idx == 2'h1)
                o_rd_addr <= sr;
              else
              begin
                o_wr.valid <= 1'b1;
                o_wr.addr <= o_rd_addr;
                o_wr.data <= sr;
                o_rd_addr <= o_rd_addr + 8'h01;
              end
            end
          I_ACK:
            if (scl_fall)
            begin
              st <= rw ? I_TX : I_RX;
              sr <= i_rd_data;
              o_sda_oe <= rw && !i_rd_data[7];
            end
          I_TX:
            if (scl_rise)
              bits <= bits + 4'h1;
            else if (scl_fall && bits == 4'h8)
            begin
              st <= I_TACK;
              bits <= 4'h0;
              o_sda_oe <= 1'b0;
              o_rd_addr <= o_rd_addr + 8'h01;
            end
            else if (scl_fall)
            begin
              sr <= {sr[6:0], 1'b0};
              o_sda_oe <= !sr[6];
            end
          I_TACK:
            if (scl_rise)
              nack <= sda_r[1];
            else if (scl_fall)
            begin
              st <= nack ? I_IDLE : I_TX;
              sr <= i_rd_data;
              o_sda_oe <= !nack && !i_rd_data[7];
            end
          default:
            st <= I_IDLE;
        endcase
      end
    end
  end

  ack_drive_a: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    st == I_RX && !start && !stop && scl_fall && bits == 4'h8 && idx != 2'h0 |=> o_sda_oe && st == I_ACK)
    else $error("byte not acknowledged");
endmodule // lpd_i2c_slave

// ### design/lpd_logic_if.sv
`timescale 1ns/1ps
// How it works
// - clock field 00 external, 01/11 internal, 10 automatic selection
// - external clock flagged absent only below about 15 kHz
// - any fast toggling counts as external clock present
// - input stuck low or high is flagged absent
// - status bit at 0CH shows external clock present while detection enabled
// - program tick comes straight from the selected slow clock
// - power save with external clock in use and present stops the internal oscillator
// - output register bit 2 turns interrupt pin into push-pull output
// - output register bit 1 drives the general output pin
// - output register bit 0 sets interrupt pin level when repurposed
// - otherwise interrupt pin is active-low open drain
// - trigger line is shared open drain, pulled low to signal
// - sent trigger holds the line low exactly three slow periods
// - writing FFH to 0DH restores every register default
// - standby whenever chip enable bit or enable pin is low
// - registers writable with pin high; settings act after start-up
// - start-up lasts 1 ms after pin rise, 500 us after bit set
// - enable pin low clears chip enable bit; bit resets to 0
// - sda moving while scl high aborts the transaction
// - bytes are 8 bits, msb first, each acknowledged
// - channel mode writes take effect on the slow clock only
module lpd_logic_if #(
  parameter int EXT_LOSS_CYC = lpd_pkg::EXT_LOSS_CYC,
  parameter int INT_OSC_CYC = lpd_pkg::INT_OSC_CYC,
  parameter int EN_START_CYC = lpd_pkg::EN_START_CYC,
  parameter int CE_START_CYC = lpd_pkg::CE_START_CYC
) (
  input wire logic i_sys_clk,
  input wire logic i_sys_rst,
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_sda_out,
  output logic o_sda_oe,
  input wire logic [1:0] i_addr_sel,
  input wire logic i_en_pin,
  input wire logic i_slow_clock_input,
  input wire logic i_trigger_line,
  output logic o_trigger_line_out,
  output logic o_trigger_line_oe,
  input wire logic i_trigger_line_send,
  output logic o_trigger_line_recv,
  input wire logic i_irq_req,
  output logic o_int_out,
  output logic o_int_oe,
  output logic o_general_output_pin,
  input wire logic i_power_save_req,
  output logic o_int_osc_en,
  output logic o_prog_tick,
  output logic o_ext_present,
  output logic o_use_ext,
  output lpd_pkg::lpd_mode_t o_mode,
  output logic o_func_en,
  output logic [lpd_pkg::CHANNEL_OPERATING_MODE_W-1:0] o_channel_operating_mode
);
  localparam int CW = 20;
  if (EXT_LOSS_CYC < 8 || EXT_LOSS_CYC >= 2**CW || INT_OSC_CYC < 8 || INT_OSC_CYC >= 2**CW
      || EN_START_CYC < 8 || EN_START_CYC >= 2**CW || CE_START_CYC < 8 || CE_START_CYC >= 2**CW)
  begin : g_chk
    $error("lpd_logic_if: count parameter out of range");
  end
  // ***********************
  // pin synchronisers
  // ***********************
  logic [2:0] pin_m;
  logic [2:0] pin_s;
  logic slow_prev;
  always_ff @(posedge i_sys_clk)
  begin
    if (i_sys_rst)
    begin
      pin_m <= 3'h1;
      pin_s <= 3'h1;
      slow_prev <= 1'b0;
    end
    else
    begin
      pin_m <= {i_en_pin, i_slow_clock_input, i_trigger_line};
      pin_s <= pin_m;
      slow_prev <= pin_s[1];
    end
  end
  logic en_s;
  logic trigger_line_s;
  logic slow_rise;
  assign en_s = pin_s[2];
  assign trigger_line_s = pin_s[0];
  assign slow_rise = pin_s[1] && !slow_prev;
  // ***********************
  // register file
  // ***********************
  lpd_pkg::lpd_wr_t wr;
  logic [7:0] rd_addr;
  logic [7:0] rd_data;
  logic wr_ok;
  logic soft_rst;
  logic rst_all;
  logic chip_en;
  logic [7:0] cfg;
  logic [2:0] output_pin_control;
  logic [lpd_pkg::CHANNEL_OPERATING_MODE_W-1:0] opm_new;
  logic opm_pend;
  assign wr_ok = wr.valid && en_s;
  assign rst_all = i_sys_rst || soft_rst;
  always_ff @(posedge i_sys_clk)
  begin
    if (i_sys_rst)
      soft_rst <= 1'b0;
    else
      soft_rst <= wr_ok && wr.addr == lpd_pkg::REG_SOFT_RST && wr.data == lpd_pkg::SOFT_RST_KEY;
  end
  always_ff @(posedge i_sys_clk)
  begin
    if (rst_all)
    begin
      chip_en <= 1'b0;
      cfg <= lpd_pkg::CONFIG_RESET;
      output_pin_control <= lpd_pkg::OUT_PIN_RESET;
    end
    else
    begin
      if (wr_ok && wr.addr == lpd_pkg::REG_CHIP_CTRL)
        chip_en <= wr.data[lpd_pkg::CHIP_EN_BIT];
      if (!en_s)
        chip_en <= 1'b0;
      if (wr_ok && wr.addr == lpd_pkg::REG_CONFIG)
        cfg <= wr.data;
      if (wr_ok && wr.addr == lpd_pkg::REG_OUT_PIN)
        output_pin_control <= wr.data[2:0];
    end
  end
  // mode writes cross onto the slow tick; a second write before it lands replaces the first
  always_ff @(posedge i_sys_clk)
  begin
    if (rst_all)
    begin
      opm_new <= lpd_pkg::CHANNEL_OPERATING_MODE_RESET;
      opm_pend <= 1'b0;
      o_channel_operating_mode <= lpd_pkg::CHANNEL_OPERATING_MODE_RESET;
    end
    else
    begin
      if (o_prog_tick && opm_pend)
      begin
        o_channel_operating_mode <= opm_new;
        opm_pend <= 1'b0;
      end
      if (wr_ok && wr.addr == lpd_pkg::REG_CHANNEL_OPERATING_MODE)
      begin
        opm_new <= wr.data[lpd_pkg::CHANNEL_OPERATING_MODE_W-1:0];
        opm_pend <= 1'b1;
      end
    end
  end
  always_comb
  begin
    rd_data = 8'h00;
    case (rd_addr)
      lpd_pkg::REG_CHIP_CTRL: rd_data[lpd_pkg::CHIP_EN_BIT] = chip_en;
      lpd_pkg::REG_CHANNEL_OPERATING_MODE: rd_data[lpd_pkg::CHANNEL_OPERATING_MODE_W-1:0] = o_channel_operating_mode;
      lpd_pkg::REG_CONFIG: rd_data = cfg;
      lpd_pkg::REG_STATUS: rd_data[lpd_pkg::EXT_USED_BIT] = cfg[lpd_pkg::CLK_DET_BIT] && o_ext_present;
      lpd_pkg::REG_OUT_PIN: rd_data[2:0] = output_pin_control;
      default: rd_data = 8'h00;
    endcase
  end
  lpd_i2c_slave u_i2c (
    .i_sys_clk(i_sys_clk),
    .i_sys_rst(i_sys_rst),
    .i_scl(i_scl),
    .i_sda(i_sda),
    .i_addr_sel(i_addr_sel),
    .i_rd_data(rd_data),
    .o_rd_addr(rd_addr),
    .o_wr(wr),
    .o_sda_oe(o_sda_oe)
  );
  assign o_sda_out = 1'b0;
  // ***********************
  // operating modes
  // ***********************
  logic run;
  logic [CW-1:0] en_age;
  logic [CW-1:0] st_cnt;
  logic [7:0] cfg_act;
  logic [2:0] gpo_act;
  assign run = chip_en && en_s;
  assign o_func_en = o_mode == lpd_pkg::MODE_NORMAL || o_mode == lpd_pkg::MODE_PSAVE;
  always_ff @(posedge i_sys_clk)
  begin
    if (rst_all || !en_s)
      en_age <= '0;
    else if (en_age != CW'(EN_START_CYC))
      en_age <= en_age + 1'b1;
  end
  always_ff @(posedge i_sys_clk)
  begin
    if (rst_all)
    begin
      o_mode <= lpd_pkg::MODE_RESET;
      st_cnt <= '0;
    end
    else
    begin
      case (o_mode)
        lpd_pkg::MODE_RESET:
          o_mode <= lpd_pkg::MODE_STANDBY;
        lpd_pkg::MODE_STANDBY:
          if (run)
          begin
            o_mode <= lpd_pkg::MODE_STARTUP;
            st_cnt <= CW'(CE_START_CYC - 1);
          end
        lpd_pkg::MODE_STARTUP:
          if (!run)
            o_mode <= lpd_pkg::MODE_STANDBY;
          else if (st_cnt != '0)
            st_cnt <= st_cnt - 1'b1;
          else if (en_age == CW'(EN_START_CYC))
            o_mode <= lpd_pkg::MODE_NORMAL;
        lpd_pkg::MODE_NORMAL:
          if (!run)
            o_mode <= lpd_pkg::MODE_STANDBY;
          else if (i_power_save_req)
            o_mode <= lpd_pkg::MODE_PSAVE;
        lpd_pkg::MODE_PSAVE:
          if (!run)
            o_mode <= lpd_pkg::MODE_STANDBY;
          else if (!i_power_save_req)
            o_mode <= lpd_pkg::MODE_NORMAL;
        default:
          o_mode <= lpd_pkg::MODE_STANDBY;
      endcase
    end
  end
  // settings written in standby are held back until start-up is done
  always_ff @(posedge i_sys_clk)
  begin
    if (rst_all)
    begin
      cfg_act <= lpd_pkg::CONFIG_RESET;
      gpo_act <= lpd_pkg::OUT_PIN_RESET;
    end
    else if (o_func_en)
    begin
      cfg_act <= cfg;
      gpo_act <= output_pin_control;
    end
  end
  // ***********************
  // clock detect and select
  // ***********************
  logic [CW-1:0] loss_cnt;
  logic [CW-1:0] osc_cnt;
  logic int_tick;
  // only a too slow clock is caught; fast clocks always look present
  always_ff @(posedge i_sys_clk)
  begin
    if (rst_all)
    begin
      loss_cnt <= '0;
      o_ext_present <= 1'b0;
    end
    else if (slow_rise)
    begin
      loss_cnt <= '0;
      o_ext_present <= 1'b1;
    end
    else if (loss_cnt == CW'(EXT_LOSS_CYC - 1))
      o_ext_present <= 1'b0;
    else
      loss_cnt <= loss_cnt + 1'b1;
  end
  assign o_use_ext = cfg_act[1:0] == lpd_pkg::CLK_EXT
                     || (cfg_act[1:0] == lpd_pkg::CLK_AUTO && o_ext_present);
  assign o_int_osc_en = o_func_en && !(o_mode == lpd_pkg::MODE_PSAVE && o_ext_present && o_use_ext);
  always_ff @(posedge i_sys_clk)
  begin
    if (rst_all || !o_int_osc_en || osc_cnt == CW'(INT_OSC_CYC - 1))
      osc_cnt <= '0;
    else
      osc_cnt <= osc_cnt + 1'b1;
  end
  assign int_tick = o_int_osc_en && osc_cnt == CW'(INT_OSC_CYC - 1);
  always_ff @(posedge i_sys_clk)
  begin
    if (rst_all)
      o_prog_tick <= 1'b0;
    else
      o_prog_tick <= o_func_en && (o_use_ext ? slow_rise : int_tick);
  end
  // ***********************
  // trigger line
  // ***********************
  logic [1:0] tin_cnt;
  logic [1:0] tout_cnt;
  logic tout_pend;
  // own drive is masked so a sent trigger does not echo back as received
  always_ff @(posedge i_sys_clk)
  begin
    if (rst_all || trigger_line_s || o_trigger_line_oe)
    begin
      tin_cnt <= 2'h0;
      o_trigger_line_recv <= 1'b0;
    end
    else
    begin
      o_trigger_line_recv <= o_prog_tick && tin_cnt == lpd_pkg::TRIGGER_LINE_IN_TICKS - 2'h1;
      if (o_prog_tick && tin_cnt != lpd_pkg::TRIGGER_LINE_IN_TICKS)
        tin_cnt <= tin_cnt + 2'h1;
    end
  end
  // start on a tick so the low time is whole slow periods
  always_ff @(posedge i_sys_clk)
  begin
    if (rst_all)
    begin
      tout_cnt <= 2'h0;
      tout_pend <= 1'b0;
    end
    else
    begin
      if (i_trigger_line_send)
        tout_pend <= 1'b1;
      if (o_prog_tick && tout_cnt != 2'h0)
        tout_cnt <= tout_cnt - 2'h1;
      else if (o_prog_tick && tout_pend)
      begin
        tout_cnt <= lpd_pkg::TRIGGER_LINE_OUT_TICKS;
        tout_pend <= i_trigger_line_send;
      end
    end
  end
  assign o_trigger_line_out = 1'b0;
  assign o_trigger_line_oe = tout_cnt != 2'h0;
  // ***********************
  // output pins
  // ***********************
  assign o_general_output_pin = gpo_act[lpd_pkg::GPO_BIT];
  assign o_int_oe = gpo_act[lpd_pkg::INT_ROLE_BIT] || i_irq_req;
  assign o_int_out = gpo_act[lpd_pkg::INT_ROLE_BIT] && gpo_act[lpd_pkg::INT_LVL_BIT];
  // ***********************
  // checks
  // ***********************
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (rst_all);
  logic [2:0] trigger_line_seen;
  logic [CW:0] quiet;
  always_ff @(posedge i_sys_clk)
  begin
    if (rst_all || !o_trigger_line_oe)
      trigger_line_seen <= 3'h0;
    else if (o_prog_tick)
      trigger_line_seen <= trigger_line_seen + 3'h1;
    if (rst_all || slow_rise)
      quiet <= '0;
    else if (quiet[CW] == 1'b0)
      quiet <= quiet + 1'b1;
  end
  sequence s_standby_run;
    o_mode == lpd_pkg::MODE_STANDBY && run;
  endsequence
  // normal may not follow standby sooner than eight cycles, whatever run does meanwhile
  sequence s_startup_hold;
    (o_mode != lpd_pkg::MODE_NORMAL) [*8];
  endsequence
  startup_delay_a: assert property (s_standby_run |=> s_startup_hold)
    else $error("start-up too short");
  startup_entry_a: assert property (s_standby_run |=> o_mode == lpd_pkg::MODE_STARTUP)
    else $error("start-up did not begin");
  standby_force_a: assert property (!run && o_mode != lpd_pkg::MODE_RESET |=> o_mode == lpd_pkg::MODE_STANDBY)
    else $error("not in standby while disabled");
  chip_en_clear_a: assert property (!en_s |=> !chip_en)
    else $error("chip enable kept with pin low");
  trigger_line_len_a: assert property ($fell(o_trigger_line_oe) |-> $past(trigger_line_seen) == 3'h2 && $past(o_prog_tick))
    else $error("trigger pulse not three slow periods");
  ext_absent_a: assert property (quiet > (CW+1)'(EXT_LOSS_CYC) |-> !o_ext_present)
    else $error("stalled clock still present");
  ext_present_a: assert property (slow_rise |=> o_ext_present)
    else $error("toggling clock not present");
  ext_tick_a: assert property (o_func_en && o_use_ext && slow_rise |=> o_prog_tick)
    else $error("selected external edge gave no tick");
  auto_fallback_a: assert property (cfg_act[1:0] == lpd_pkg::CLK_AUTO && !o_ext_present |-> !o_use_ext)
    else $error("auto mode kept absent clock");
  int_od_a: assert property (!gpo_act[lpd_pkg::INT_ROLE_BIT] |-> !o_int_out && o_int_oe == i_irq_req)
    else $error("interrupt pin not open drain");
  int_gpo_a: assert property (gpo_act[lpd_pkg::INT_ROLE_BIT] |-> o_int_oe && o_int_out == gpo_act[0])
    else $error("repurposed interrupt level wrong");
  opm_sync_a: assert property ($changed(o_channel_operating_mode) && !$past(rst_all) |-> $past(o_prog_tick))
    else $error("mode change off the slow tick");
  gpo_write_a: assert property (wr_ok && wr.addr == lpd_pkg::REG_OUT_PIN && o_mode == lpd_pkg::MODE_NORMAL
    && run ##1 o_mode == lpd_pkg::MODE_NORMAL |=> o_general_output_pin == $past(wr.data[1], 2))
    else $error("general output not following write");
  soft_rst_a: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    wr_ok && wr.addr == lpd_pkg::REG_SOFT_RST && wr.data == lpd_pkg::SOFT_RST_KEY
    |=> ##1 !chip_en && cfg == lpd_pkg::CONFIG_RESET && o_mode == lpd_pkg::MODE_RESET)
    else $error("soft reset did not clear");
endmodule // lpd_logic_if

// ### dv/lpd_host_bfm.sv
`timescale 1ns/1ps
module lpd_host_bfm (
  input wire logic i_sys_clk,
  input wire logic i_sda,
  output logic o_scl,
  output logic o_sda_low
);
  // open drain: sda is only pulled low, the pull-up gives the high
  int nacks = 0;
  initial
  begin
    o_scl = 1'b1;
    o_sda_low = 1'b0;
  end
  task automatic wt(int n);
    repeat (n) @(negedge i_sys_clk);
  endtask
  // sda moves mid low phase, never beside an scl edge
  task automatic bit_io(input logic b, output logic r);
    wt(4);
    o_sda_low = ~b;
    wt(4);
    o_scl = 1'b1;
    wt(8);
    r = i_sda;
    o_scl = 1'b0;
  endtask
  task automatic byte_io(input logic [7:0] tx, input logic chk, output logic [7:0] rx);
    logic a;
    for (int i = 7; i >= 0; i--) bit_io(tx[i], rx[i]);
    bit_io(1'b1, a);
    if (chk && a) nacks++;
  endtask
  task automatic start();
    wt(4);
    o_sda_low = 1'b0;
    wt(4);
    o_scl = 1'b1;
    wt(8);
    o_sda_low = 1'b1;
    wt(8);
    o_scl = 1'b0;
  endtask
  task automatic stop();
    wt(4);
    o_sda_low = 1'b1;
    wt(4);
    o_scl = 1'b1;
    wt(8);
    o_sda_low = 1'b0;
    wt(8);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] x;
    start();
    byte_io(8'h64, 1'b1, x);
    byte_io(a, 1'b1, x);
    byte_io(d, 1'b1, x);
    stop();
  endtask
  // single byte read, closed by a nack
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    logic [7:0] x;
    start();
    byte_io(8'h64, 1'b1, x);
    byte_io(a, 1'b1, x);
    start();
    byte_io(8'h65, 1'b1, x);
    byte_io(8'hff, 1'b0, d);
    stop();
  endtask
endmodule // lpd_host_bfm

// ### dv/tb_top.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin err_total++; $display("[ERR] %s exp %0h got %0h", nm, e, g); end end
module tb_top;
  localparam int OSC = 16;
  localparam int LOSS = 200;
  int err_total = 0;
  int check_count = 0;
  int cyc = 0;
  int hits = 0;
  logic i_sys_clk = 1'b0;
  logic rst = 1'b1;
  logic en_pin = 1'b1;
  logic ext = 1'b0;
  logic ext_run = 1'b1;
  logic trigger_line_send = 1'b0;
  logic irq = 1'b0;
  logic psave = 1'b0;
  logic trigger_line_low = 1'b0;
  logic scl, host_low, sda_oe, trigger_line_oe, recv, int_out, int_oe, output_pin_control, osc_en, use_ext, ext_pres, func_en;
  lpd_pkg::lpd_mode_t mode;
  logic [5:0] chmode;
  logic [7:0] rd;
  wire sda = ~(host_low | sda_oe);
  wire trigger_line = ~(trigger_line_low | trigger_line_oe);
  lpd_logic_if #(.EXT_LOSS_CYC(LOSS), .INT_OSC_CYC(OSC), .EN_START_CYC(40), .CE_START_CYC(200)) dut (
    .i_sys_clk(i_sys_clk), .i_sys_rst(rst), .i_scl(scl), .i_sda(sda), .o_sda_out(), .o_sda_oe(sda_oe),
    .i_addr_sel(2'h0), .i_en_pin(en_pin), .i_slow_clock_input(ext), .i_trigger_line(trigger_line),
    .o_trigger_line_out(), .o_trigger_line_oe(trigger_line_oe), .i_trigger_line_send(trigger_line_send), .o_trigger_line_recv(recv),
    .i_irq_req(irq), .o_int_out(int_out), .o_int_oe(int_oe), .o_general_output_pin(output_pin_control),
    .i_power_save_req(psave), .o_int_osc_en(osc_en), .o_prog_tick(), .o_ext_present(ext_pres),
    .o_use_ext(use_ext), .o_mode(mode), .o_func_en(func_en), .o_channel_operating_mode(chmode));
  lpd_host_bfm host (.i_sys_clk(i_sys_clk), .i_sda(sda), .o_scl(scl), .o_sda_low(host_low));
  always #2 i_sys_clk = ~i_sys_clk;
  // slow clock locked to the system clock, toggling on its falling edges every four cycles
  always #16 if (ext_run) ext = ~ext;
  always @(posedge i_sys_clk)
  begin
    cyc++;
    if (cyc == 80000)
    begin
      err_total++;
      print_verdict();
    end
  end
  task automatic wt(int n);
    repeat (n) @(negedge i_sys_clk);
  endtask
  task automatic print_verdict();
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // ************************
  // scenarios
  // ************************
  task automatic t_start();
    int n;
    host.rd(8'h00, rd);
    `CHK("chip_ctrl", 8'h00, rd)
    `CHK("func_en", 1'b0, func_en)
    host.wr(8'h00, 8'h01);
    `CHK("mode", lpd_pkg::MODE_STARTUP, mode)
    for (n = 0; n < 400 && mode == lpd_pkg::MODE_STARTUP; n++) wt(1);
    `CHK("start_len", 1'b1, n > 100 && n < 200)
    `CHK("mode", lpd_pkg::MODE_NORMAL, mode)
    host.wr(8'h01, 8'h2a);
    wt(OSC + 2);
    `CHK("channel_operating_mode", 6'h2a, chmode)
  endtask
  task automatic t_gpo();
    host.wr(8'h0e, 8'h06);
    `CHK("gpo", 1'b1, output_pin_control)
    `CHK("int_pin", 2'b10, {int_oe, int_out})
    host.wr(8'h0e, 8'h05);
    `CHK("int_pin", 3'b110, {int_oe, int_out, output_pin_control})
    host.wr(8'h0e, 8'h03);
    irq = 1'b1;
    wt(2);
    `CHK("int_pin", 2'b10, {int_oe, int_out})
    irq = 1'b0;
    wt(2);
    `CHK("int_pin", 2'b00, {int_oe, int_out})
  endtask
  task automatic t_clk();
    logic [3:0] want = 4'b0101;
    ext_run = 1'b1;
    for (int c = 0; c < 4; c++)
    begin
      host.wr(8'h08, 8'(c));
      `CHK("use_ext", want[c], use_ext)
    end
    host.rd(8'h0c, rd);
    `CHK("status", 8'h01, rd)
    host.wr(8'h08, 8'h02);
    psave = 1'b1;
    wt(3);
    `CHK("osc_en", 1'b0, osc_en)
    psave = 1'b0;
    ext_run = 1'b0;
    wt(LOSS + 20);
    `CHK("ext_pres", 1'b0, ext_pres)
    `CHK("use_ext", 1'b0, use_ext)
    host.rd(8'h0c, rd);
    `CHK("status", 8'h00, rd)
  endtask
  // line low for len cycles, watching for a recognised trigger during it and 40 cycles after
  task automatic trigger_line_in(int len, logic want);
    hits = 0;
    for (int i = 0; i < len + 40; i++)
    begin
      trigger_line_low = (i < len);
      wt(1);
      hits += int'(recv === 1'b1);
    end
    `CHK("trigger_line_recv", want, hits > 0)
  endtask
  task automatic t_trigger_line();
    int n;
    trigger_line_send = 1'b1;
    wt(1);
    trigger_line_send = 1'b0;
    for (n = 0; n < 40 && trigger_line_oe !== 1'b1; n++) wt(1);
    for (n = 0; n < 100 && trigger_line_oe === 1'b1; n++) wt(1);
    `CHK("trigger_line_len", 3 * OSC, n)
    trigger_line_in(8, 1'b0);
    trigger_line_in(3 * OSC + 8, 1'b1);
  endtask
  task automatic t_soft();
    host.wr(8'h0d, lpd_pkg::SOFT_RST_KEY);
    `CHK("mode", lpd_pkg::MODE_STANDBY, mode)
    host.rd(8'h08, rd);
    `CHK("config", lpd_pkg::CONFIG_RESET, rd)
    host.rd(8'h0e, rd);
    `CHK("out_pin", 8'h00, rd)
    host.wr(8'h00, 8'h01);
    en_pin = 1'b0;
    wt(8);
    `CHK("mode", lpd_pkg::MODE_STANDBY, mode)
    en_pin = 1'b1;
    wt(8);
    host.rd(8'h00, rd);
    `CHK("chip_ctrl", 8'h00, rd)
    `CHK("nacks", 0, host.nacks)
  endtask
  initial
  begin
    repeat (12) @(negedge i_sys_clk);
    rst = 1'b0;
    wt(4);
    t_start();
    t_gpo();
    t_clk();
    t_trigger_line();
    t_soft();
    print_verdict();
  end
endmodule // tb_top
